//--- rtl/pmc_pkg.sv
// Package for the power management control block
package pmc_pkg;

	localparam logic [7:0]  PMC_CTRL_ADDR     = 8'h84;
	localparam logic [7:0]  PMC_PROBE_ADDR    = 8'h64;
	localparam logic [31:0] PMC_PROBE_VALUE   = 32'h87654321;

	localparam int          PMC_STATE_LSB     = 12;
	localparam int          PMC_PHYRST_BIT    = 10;
	localparam int          PMC_WOLEN_BIT     = 9;
	localparam int          PMC_EDEN_BIT      = 8;
	localparam int          PMC_TYPE_BIT      = 6;
	localparam int          PMC_CAUSE_LSB     = 4;
	localparam int          PMC_PULSE_BIT     = 3;
	localparam int          PMC_POL_BIT       = 2;
	localparam int          PMC_PINEN_BIT     = 1;
	localparam int          PMC_READY_BIT     = 0;

	localparam logic [1:0]  PMC_CAUSE_NONE    = 2'h0;
	localparam logic [1:0]  PMC_CAUSE_ENERGY  = 2'h1;
	localparam logic [1:0]  PMC_CAUSE_FRAME   = 2'h2;

	localparam int          PMC_CLK_HZ        = 25000000;
	localparam int          PMC_PHYRST_US     = 100;
	localparam int          PMC_PULSE_MS      = 50;
	localparam int          PMC_READY_CYC     = 16;
	localparam int          PMC_PHYRST_CYC    = (PMC_CLK_HZ / 1000000) * PMC_PHYRST_US;
	localparam int          PMC_PULSE_CYC     = (PMC_CLK_HZ / 1000) * PMC_PULSE_MS;

	typedef enum logic [1:0] {
		PMC_FULL_POWER   = 2'b00,
		PMC_WAKE_DETECT  = 2'b01,
		PMC_ENERGY_SENSE = 2'b10,
		PMC_RESERVED     = 2'b11
	} pmc_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} pmc_req_t;

	typedef struct packed {
		logic out;
		logic oe;
	} pmc_pin_t;

endpackage : pmc_pkg

//--- rtl/pmc_timer.sv
// Load-and-count-down timer with a busy level
`timescale 1ns/1ps
`default_nettype none
module pmc_timer
	import pmc_pkg::*;
#(
	parameter int WIDTH = 24
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	// Control
	input  wire logic             start,
	input  wire logic             abort,
	input  wire logic [WIDTH-1:0] loadValue,
	// Status
	output logic                  busy
);
	logic [WIDTH-1:0] count_ff;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count_ff <= '0;
		end else if (abort) begin
			count_ff <= '0;
		end else if (start) begin
			count_ff <= loadValue;
		end else if (count_ff != '0) begin
			count_ff <= count_ff - 1'b1;
		end
	end

	assign busy = (count_ff != '0);
endmodule : pmc_timer
`default_nettype wire

//--- rtl/pmc_power_ctrl.sv
// Power management control register, wake logic and power-event pin
// How it works
// [RULE_01] Power state bits 13-12: 00 full, 01 wake detect, 10 energy sense, 11 reserved.
// [RULE_02] Power state resets to 00 and self-clears back to 00 on wake.
// [RULE_03] In reduced power, any write to the endian probe register wakes the device.
// [RULE_04] Host writes only the probe register while the alive flag is clear.
// [RULE_05] After reset or wake, writes are ignored until one read is seen.
// [RULE_06] Writing 1 to bit 10 resets transceiver at least 100us, then self-clears.
// [RULE_07] Writes to the transceiver reset bit are ignored while it reads high.
// [RULE_08] Frame wake event with bit 9 and pin enable drives the pin per pulse select.
// [RULE_09] Frame wake event with bit 9 set raises the interrupt regardless of pin enable.
// [RULE_10] Energy event with bit 8 and pin enable drives the pin per pulse select.
// [RULE_11] Energy event with bit 8 set raises the interrupt regardless of pin enable.
// [RULE_12] Bit 6 clear gives open-drain pin, set gives push-pull; resets to 0.
// [RULE_13] Open-drain pin ignores polarity and is always active low.
// [RULE_14] Wake cause bits 5-4: 00 none, 01 energy, 10 frame, 11 multiple.
// [RULE_15] Wake cause bits clear by writing 1, only when full power and alive.
// [RULE_16] A wake cause bit clears only if its event source is also clear.
// [RULE_17] Bit 3 selects pulsed or static power-event output.
// [RULE_18] The control register stays readable in every power-saving state.
// [RULE_19] Pulse mode asserts 50ms per event; static holds until cause or enable clears. The code pulses only when a cause bit newly sets.
// [RULE_20] Bit 2 makes push-pull output active high when set, low when clear.
// [RULE_21] Pin enable bit 1 gates only the pin, never the interrupt.
// [RULE_22] Alive flag bit 0 sets once the device has stabilised after reset or wake.
// [RULE_23] Transceiver reset hold is timed by an internal counter on the system clock.
// [RULE_24] Interrupt is OR of enabled sources, held until the cause bit clears.
`timescale 1ns/1ps
`default_nettype none
module pmc_power_ctrl
	import pmc_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	// Wake event sources, level while pending
	input  wire logic        wakeFrameEvent,
	input  wire logic        energyEvent,
	// Power-event pin and interrupt
	output logic             powerEventOut,
	output logic             powerEventOe,
	output logic             powerEventIrq,
	// Transceiver reset and state
	output logic             transceiverReset,
	output logic [1:0]       powerState
);
	pmc_req_t   req;
	pmc_pin_t   pin;
	pmc_state_t state_ff;
	logic [1:0] cause_ff;
	logic       wolEn_ff;
	logic       edEn_ff;
	logic       drvType_ff;
	logic       pulseSel_ff;
	logic       pol_ff;
	logic       pinEn_ff;
	logic       ready_ff;
	logic       readSeen_ff;
	logic [4:0] readyCnt_ff;
	logic [23:0] pulseCnt_ff;
	logic       phyRstLoad;
	logic       phyBusy;
	logic       active;
	logic       nxt_pinActive;
	logic       nxt_irq;
	logic       wrEnable;
	logic       ctrlWr;
	logic       probeWr;
	logic       lowPower;
	logic       wake;
	logic       frameHit;
	logic       energyHit;
	logic [1:0] clrMask;
	logic [31:0] nxt_rdata;

	assign req = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};
	assign lowPower  = (state_ff != PMC_FULL_POWER);
	assign wrEnable  = req.wr && readSeen_ff;                              // RULE_05
	// Other addresses are dropped while not alive, protecting against stray writes
	assign ctrlWr    = wrEnable && ready_ff && (req.addr == PMC_CTRL_ADDR); // RULE_04
	assign probeWr   = wrEnable && (req.addr == PMC_PROBE_ADDR);
	assign wake      = lowPower && probeWr;                                 // RULE_03
	assign frameHit  = wakeFrameEvent && wolEn_ff;
	assign energyHit = energyEvent && edEn_ff;

	// Transceiver reset timer
	assign phyRstLoad = ctrlWr && req.wdata[PMC_PHYRST_BIT] && !phyBusy;   // RULE_07
	pmc_timer #(
		.WIDTH     (24)
	) u_phy_timer (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.start     (phyRstLoad),
		.abort     (1'b0),
		.loadValue (24'(PMC_PHYRST_CYC)),                                 // RULE_23
		.busy      (phyBusy)
	);

	// Power state
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= PMC_FULL_POWER;                                    // RULE_02
		end else if (wake) begin
			state_ff <= PMC_FULL_POWER;                                    // RULE_02
		end else if (ctrlWr) begin
			// Reserved encoding is not accepted so the state stays legal
			unique case (req.wdata[PMC_STATE_LSB +: 2])
				2'b00:   state_ff <= PMC_FULL_POWER;                      // RULE_01
				2'b01:   state_ff <= PMC_WAKE_DETECT;                     // RULE_01
				2'b10:   state_ff <= PMC_ENERGY_SENSE;                    // RULE_01
				default: state_ff <= state_ff;
			endcase
		end
	end

	// Write gate: one read after reset or wake arms the write path
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			readSeen_ff <= 1'b0;
		end else if (wake) begin
			readSeen_ff <= 1'b0;                                           // RULE_05
		end else if (req.rd) begin
			readSeen_ff <= 1'b1;                                           // RULE_05
		end
	end

	// Alive flag after a short settle time
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			readyCnt_ff <= '0;
			ready_ff    <= 1'b0;
		end else if (wake || (ctrlWr && req.wdata[PMC_STATE_LSB +: 2] != 2'b00
				&& req.wdata[PMC_STATE_LSB +: 2] != 2'b11)) begin
			readyCnt_ff <= '0;
			ready_ff    <= 1'b0;
		end else if (!lowPower && !ready_ff) begin
			if (readyCnt_ff == 5'(PMC_READY_CYC - 1)) begin
				ready_ff <= 1'b1;                                          // RULE_22
			end else begin
				readyCnt_ff <= readyCnt_ff + 5'h01;
			end
		end
	end

	// Configuration bits
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wolEn_ff    <= 1'b0;
			edEn_ff     <= 1'b0;
			drvType_ff  <= 1'b0;                                           // RULE_12
			pulseSel_ff <= 1'b0;
			pol_ff      <= 1'b0;
			pinEn_ff    <= 1'b0;
		end else if (ctrlWr) begin
			wolEn_ff    <= req.wdata[PMC_WOLEN_BIT];
			edEn_ff     <= req.wdata[PMC_EDEN_BIT];
			drvType_ff  <= req.wdata[PMC_TYPE_BIT];
			pulseSel_ff <= req.wdata[PMC_PULSE_BIT];                       // RULE_17
			pol_ff      <= req.wdata[PMC_POL_BIT];
			pinEn_ff    <= req.wdata[PMC_PINEN_BIT];
		end
	end

	// Wake cause: event set wins over a clear in the same cycle
	assign clrMask = (ctrlWr && !lowPower && ready_ff)
		? req.wdata[PMC_CAUSE_LSB +: 2] : 2'b00;                          // RULE_15
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cause_ff <= PMC_CAUSE_NONE;
		end else begin
			// Energy bit 0, frame bit 1; both set reads as multiple
			cause_ff[0] <= energyHit || (cause_ff[0] && !(clrMask[0] && !energyEvent)); // RULE_14 RULE_16
			cause_ff[1] <= frameHit || (cause_ff[1] && !(clrMask[1] && !wakeFrameEvent)); // RULE_14 RULE_16
		end
	end

	// Pulse timer: restarts whenever a wake cause bit newly sets, so each such set gets a full pulse
	logic [1:0] causeDly_ff;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			causeDly_ff <= 2'b00;
			pulseCnt_ff <= '0;
		end else begin
			causeDly_ff <= cause_ff;
			if (|(cause_ff & ~causeDly_ff)) begin
				pulseCnt_ff <= 24'(PMC_PULSE_CYC);                        // RULE_19
			end else if (pulseCnt_ff != '0) begin
				pulseCnt_ff <= pulseCnt_ff - 24'h000001;
			end
		end
	end

	always_comb begin
		active  = (cause_ff[1] && wolEn_ff) || (cause_ff[0] && edEn_ff);   // RULE_24
		nxt_irq = active;                                                  // RULE_09 RULE_11 RULE_21
		if (!pinEn_ff) begin
			nxt_pinActive = 1'b0;                                          // RULE_21
		end else if (pulseSel_ff) begin
			nxt_pinActive = active && (pulseCnt_ff != '0);                // RULE_19
		end else begin
			nxt_pinActive = active;                                        // RULE_08 RULE_10
		end
		if (!drvType_ff) begin
			pin.out = 1'b0;                                                // RULE_13
			pin.oe  = nxt_pinActive;                                       // RULE_12
		end else begin
			pin.out = pol_ff ? nxt_pinActive : !nxt_pinActive;            // RULE_20
			pin.oe  = 1'b1;                                                // RULE_12
		end
	end

	// Output registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			powerEventOut    <= 1'b0;
			powerEventOe     <= 1'b0;
			powerEventIrq    <= 1'b0;
			transceiverReset <= 1'b0;
			powerState       <= PMC_FULL_POWER;
		end else begin
			powerEventOut    <= pin.out;
			powerEventOe     <= pin.oe;
			powerEventIrq    <= nxt_irq;
			transceiverReset <= phyBusy || phyRstLoad;                     // RULE_06
			powerState       <= state_ff;
		end
	end

	// Read data, valid the cycle after the strobe
	always_comb begin
		nxt_rdata = 32'h00000000;
		if (req.addr == PMC_CTRL_ADDR) begin
			nxt_rdata[PMC_STATE_LSB +: 2] = state_ff;                     // RULE_18
			nxt_rdata[PMC_PHYRST_BIT]     = phyBusy;                       // RULE_06
			nxt_rdata[PMC_WOLEN_BIT]      = wolEn_ff;
			nxt_rdata[PMC_EDEN_BIT]       = edEn_ff;
			nxt_rdata[PMC_TYPE_BIT]       = drvType_ff;
			nxt_rdata[PMC_CAUSE_LSB +: 2] = cause_ff;
			nxt_rdata[PMC_PULSE_BIT]      = pulseSel_ff;
			nxt_rdata[PMC_POL_BIT]        = pol_ff;
			nxt_rdata[PMC_PINEN_BIT]      = pinEn_ff;
			nxt_rdata[PMC_READY_BIT]      = ready_ff;
		end else if (req.addr == PMC_PROBE_ADDR) begin
			nxt_rdata = PMC_PROBE_VALUE;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			regRdata <= 32'h00000000;
		end else if (req.rd) begin
			regRdata <= nxt_rdata;
		end else begin
			regRdata <= 32'h00000000;
		end
	end
endmodule : pmc_power_ctrl
`default_nettype wire

//--- sim/pmc_host.sv
// Host bus master model for the register port
`timescale 1ns/1ps
`default_nettype none
module pmc_host (
	// Clock
	input  wire logic        sys_clk,
	// Register port
	output logic      [7:0]  regAddr,
	output logic      [31:0] regWdata,
	output logic             regWr,
	output logic             regRd
);
	initial begin
		regAddr  = 8'h00;
		regWdata = 32'h0;
		regWr    = 1'b0;
		regRd    = 1'b0;
	end
	// One strobe cycle; lines then show inverted values so stale data is never reused
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= w;
		regRd    <= !w;
		@(posedge sys_clk);
		regWr    <= 1'b0;
		regRd    <= 1'b0;
		regAddr  <= ~a;
		regWdata <= ~d;
	endtask : acc
endmodule : pmc_host
`default_nettype wire

//--- sim/pmc_power_ctrl_assertions.sv
// Port checks for the power management control block
`timescale 1ns/1ps
`default_nettype none
module pmc_power_ctrl_assertions
	import pmc_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        nrst,
	// Register port
	input wire logic [7:0]  regAddr,
	input wire logic [31:0] regWdata,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regRdata,
	// Events and outputs
	input wire logic        wakeFrameEvent,
	input wire logic        energyEvent,
	input wire logic        powerEventOut,
	input wire logic        powerEventOe,
	input wire logic        powerEventIrq,
	input wire logic        transceiverReset,
	input wire logic [1:0]  powerState
);
	localparam int PHY_HOLD = 2500;
	localparam int PHY_MAX  = 3000;
	logic [11:0] phyCnt_ff;
	wire         anyEvt = wakeFrameEvent | energyEvent;
	// High-cycle count; a hung reset trips the ceiling before the counter wraps
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			phyCnt_ff <= 12'h0;
		end else begin
			phyCnt_ff <= transceiverReset ? phyCnt_ff + 12'h1 : 12'h0;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence sPhyRise;
		!transceiverReset ##1 transceiverReset;
	endsequence
	sequence sPhyFall;
		transceiverReset ##1 !transceiverReset;
	endsequence
	AST_PHY_CAUSE:
	assert property (sPhyRise |-> $past(regWr) && $past(regAddr) == PMC_CTRL_ADDR
		&& $past(regWdata[10])) else $error("transceiver reset without write");
	AST_PHY_HOLD:
	assert property (sPhyFall |-> phyCnt_ff >= PHY_HOLD) else $error("reset hold short");
	AST_PHY_CLEAR:
	assert property (phyCnt_ff <= PHY_MAX) else $error("reset never self-clears");
	AST_STATE_LEGAL:
	assert property (powerState != 2'h3) else $error("reserved power state");
	AST_STATE_ENTRY:
	// State register plus output register: the write sits two samples back
	assert property ($changed(powerState) && powerState != 2'h0 |-> $past(regWr, 2)
		&& $past(regAddr, 2) == PMC_CTRL_ADDR && $past(regWdata[13:12], 2) == powerState)
		else $error("state change without control write");
	AST_WAKE:
	assert property ($changed(powerState) && powerState == 2'h0 |-> $past(regWr, 2)
		&& $past(regAddr, 2) == PMC_PROBE_ADDR) else $error("wake without probe write");
	AST_IRQ_CAUSE:
	assert property ($rose(powerEventIrq) |-> $past(anyEvt) || $past(anyEvt, 2)
		|| $past(anyEvt, 3)) else $error("interrupt without event");
	AST_IRQ_HOLD:
	assert property ($fell(powerEventIrq) |-> $past(regWr) || $past(regWr, 2)
		|| $past(regWr, 3)) else $error("interrupt dropped without write");
	AST_READ_STATE:
	assert property ($past(regRd) && $past(regAddr) == PMC_CTRL_ADDR |->
		{regRdata[13:12], regRdata[10]} == {$past(powerState), $past(transceiverReset)})
		else $error("read data disagrees with state");
endmodule : pmc_power_ctrl_assertions
bind pmc_power_ctrl pmc_power_ctrl_assertions chk_i (.sys_clk, .nrst, .regAddr,
	.regWdata, .regWr, .regRd, .regRdata, .wakeFrameEvent, .energyEvent,
	.powerEventOut, .powerEventOe, .powerEventIrq, .transceiverReset, .powerState);
`default_nettype wire

//--- sim/power_management_control_bench.sv
// Self-checking bench for the power management control block
`timescale 1ns/1ps
`default_nettype none
module power_management_control_bench;
	import pmc_pkg::*;
	localparam logic [31:0] CFG = 32'h346;
	logic        sys_clk, nrst, regWr, regRd, rdPend, wakeFrameEvent, energyEvent;
	logic        powerEventOut, powerEventOe, powerEventIrq, transceiverReset;
	logic [1:0]  powerState;
	logic [7:0]  regAddr;
	logic [31:0] regWdata, regRdata, lfsr;
	logic [31:0] expQ[$];
	int          n_errors = 0, n_checks = 0, tick = 0, i, n;
	pmc_power_ctrl uut (.sys_clk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.wakeFrameEvent, .energyEvent, .powerEventOut, .powerEventOe, .powerEventIrq,
		.transceiverReset, .powerState);
	pmc_host host (.sys_clk, .regAddr, .regWdata, .regWr, .regRd);
	function automatic logic [31:0] nxtRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxtRand
	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		n_checks++;
		if (seen !== expv) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, expv);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task automatic rdx(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		host.acc(1'b0, a, 32'h0);
	endtask : rdx
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.acc(1'b1, a, d);
	endtask : wr
	// Ends at a falling edge so outputs are settled
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : cyc
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) rdPend <= regRd;
	always @(negedge sys_clk) begin
		if (rdPend === 1'b1)
			chk(regRdata, expQ.size() ? expQ.pop_front() : 32'hDEADBEEF);
	end
	always @(posedge sys_clk) begin
		tick <= tick + 1;
		if (tick == 12000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		nrst = 1'b0;
		wakeFrameEvent = 1'b0;
		energyEvent = 1'b0;
		lfsr = 32'h7B94FA73;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		cyc(20);
		wr(PMC_CTRL_ADDR, CFG);
		rdx(PMC_CTRL_ADDR, 32'h1);
		rdx(8'h80, 32'h0);
		wr(PMC_CTRL_ADDR, CFG);
		rdx(PMC_CTRL_ADDR, CFG | 32'h1);
		$display("register test done");
		wr(PMC_CTRL_ADDR, CFG | 32'h400);
		wr(PMC_CTRL_ADDR, CFG);
		rdx(PMC_CTRL_ADDR, CFG | 32'h401);
		cyc(0);
		chk(32'(transceiverReset), 32'h1);
		for (n = 4; n < 3000 && transceiverReset === 1'b1; n++) cyc(1);
		chk(32'(n >= 2500 && n < 3000), 32'h1);
		rdx(PMC_CTRL_ADDR, CFG | 32'h1);
		$display("transceiver reset test done");
		// Codes 1 energy, 2 frame, 3 both
		for (i = 1; i < 4; i++) begin
			wakeFrameEvent <= i[1];
			energyEvent <= i[0];
			cyc(4);
			chk(32'({powerEventIrq, powerEventOe, powerEventOut}), 32'h7);
			rdx(PMC_CTRL_ADDR, CFG | 32'h1 | 32'(i << 4));
			wr(PMC_CTRL_ADDR, CFG | 32'h30);
			rdx(PMC_CTRL_ADDR, CFG | 32'h1 | 32'(i << 4));
			if (i == 3) begin
				wr(PMC_CTRL_ADDR, CFG & ~32'h2);
				cyc(3);
				chk(32'({powerEventIrq, powerEventOut}), 32'h2);
				wr(PMC_CTRL_ADDR, 32'h306);
				cyc(3);
				chk(32'({powerEventOe, powerEventOut}), 32'h2);
			end
			wakeFrameEvent <= 1'b0;
			energyEvent <= 1'b0;
			wr(PMC_CTRL_ADDR, CFG | 32'h30);
			cyc(3);
			chk(32'(powerEventIrq), 32'h0);
			rdx(PMC_CTRL_ADDR, CFG | 32'h1);
		end
		$display("wake event test done");
		// Pulse mode, push-pull active low; the 50 ms end is beyond the run budget
		wr(PMC_CTRL_ADDR, 32'h34A);
		wakeFrameEvent <= 1'b1;
		cyc(4);
		chk(32'({powerEventIrq, powerEventOe, powerEventOut}), 32'h6);
		wakeFrameEvent <= 1'b0;
		wr(PMC_CTRL_ADDR, 32'h37A);
		cyc(3);
		chk(32'({powerEventIrq, powerEventOe, powerEventOut}), 32'h3);
		$display("pulse polarity test done");
		for (i = 1; i < 3; i++) begin
			wr(PMC_CTRL_ADDR, CFG | 32'(i << 12));
			cyc(1);
			chk(32'(powerState), 32'(i));
			rdx(PMC_CTRL_ADDR, CFG | 32'(i << 12));
			lfsr = nxtRand(lfsr);
			wr(PMC_PROBE_ADDR, lfsr);
			cyc(1);
			chk(32'(powerState), 32'h0);
			cyc(20);
			wr(PMC_CTRL_ADDR, 32'h0);
			rdx(PMC_CTRL_ADDR, CFG | 32'h1);
		end
		wr(PMC_CTRL_ADDR, CFG | 32'h3000);
		cyc(1);
		chk(32'(powerState), 32'h0);
		$display("power state test done");
		end_of_test();
	end
endmodule : power_management_control_bench
`default_nettype wire
